// >>> src/pcg_consts.svh
// Register map, field limits and timing constants of the gearing block.
// Overview of operation
// - Command rate is pulse rate times active numerator over denominator.
// - Primary numerator spans 1 to 32767, resets to 1, acts in position mode.
// - One denominator spans 1 to 32767, resets to 1, serves every numerator.
// - The active numerator is the primary one or one of three further ones.
// - In internal position mode the select inputs pick the command target.
// - The position loop gain spans 0 to 1023 rad/s, in position mode only.
// - The feed-forward gain spans 10 to 20000 in 1/10000 steps.
// - With pulse inhibit active in position mode, command pulses are ignored.
// - The trigger is a rising edge, and a select input at 1 is contact on.
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH
// ==========================================================================
// Register indexes; the byte address is four times the index.
`define PCG_IDX_SMOOTH   10'h108
`define PCG_IDX_NUM1     10'h12C
`define PCG_IDX_DEN      10'h12D
`define PCG_IDX_PGAIN    10'h200
`define PCG_IDX_FFG      10'h202
`define PCG_IDX_NUM2     10'h300
`define PCG_IDX_NUM3     10'h301
`define PCG_IDX_NUM4     10'h302
`define PCG_IDX_CTRL     10'h310
`define PCG_IDX_CMDPOS   10'h311
`define PCG_IDX_FILTPOS  10'h312
`define PCG_IDX_PERR     10'h313
`define PCG_IDX_TBL_HI   7'h64
// ==========================================================================
// Field limits and reset values.
`define PCG_GEAR_MIN     16'h0001
`define PCG_GEAR_MAX     16'h7FFF
`define PCG_SMOOTH_MIN   16'h0000
`define PCG_SMOOTH_MAX   16'h03E8
`define PCG_PGAIN_MIN    16'h0000
`define PCG_PGAIN_MAX    16'h03FF
`define PCG_FFG_MIN      16'h000A
`define PCG_FFG_MAX      16'h4E20
`define PCG_RST_SMOOTH   16'h0000
`define PCG_RST_GEAR     16'h0001
`define PCG_RST_PGAIN    16'h0023
`define PCG_RST_FFG      16'h1388
`define PCG_FFG_SCALE    48'sh0000_0000_2710
`define PCG_SMOOTH_UNIT  16'h000A
// ==========================================================================
// Control bits and timing.
`define PCG_CTRL_POS     0
`define PCG_CTRL_INT     1
`define PCG_SAMPLE_NS    1000000
`define PCG_CLK_NS       20
`endif

// >>> src/pcg_pkg.sv
// Types shared by the gearing block.
`default_nettype none
package pcg_pkg;
    // ======================================================================
    // Digital inputs of the drive, carried together.
    typedef struct packed {
        logic       pulse;
        logic       dir;
        logic       inhibit;
        logic       trigger;
        logic [2:0] select;
        logic [1:0] num_sel;
    } pcg_pins_s;

    // Bus handshake states.
    typedef enum logic {
        PCG_BUS_IDLE = 1'b0,
        PCG_BUS_ACK  = 1'b1
    } pcg_bus_e;

    typedef logic signed [31:0] pcg_pos_t;
endpackage
`default_nettype wire

// >>> src/pcg_top.sv
// Position command gearing, smoothing and loop gain with an Avalon-MM slave.
`default_nettype none
`include "pcg_consts.svh"
module pcg_top
    import pcg_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = `PCG_SAMPLE_NS / `PCG_CLK_NS
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire pcg_pins_s   pins,
    input  wire pcg_pos_t    feedback_position,
    output pcg_pos_t         command_position,
    output pcg_pos_t         smoothed_position,
    output pcg_pos_t         position_error,
    output pcg_pos_t         speed_reference
);
    // ======================================================================
    // Elaboration check.
    generate
        if (SAMPLE_CYCLES < 1) begin : g_bad
            $error("SAMPLE_CYCLES must be at least one");
        end
    endgenerate

    // ======================================================================
    // Reset release.
    logic rst_s1_q;
    logic rst_q_n;

    // The release is synchronised so no flop leaves reset on a split edge.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_q_n  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q_n  <= rst_s1_q;
        end
    end

    // ======================================================================
    // Pin synchronisers.
    pcg_pins_s pin_s1_q;
    pcg_pins_s pin_s2_q;
    pcg_pins_s pin_s3_q;

    // Stage one feeds only stage two; edges compare stages two and three.
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            pin_s1_q <= pins;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    logic pulse_ev;
    logic trig_ev;
    assign pulse_ev = pin_s2_q.pulse & ~pin_s3_q.pulse;
    assign trig_ev  = pin_s2_q.trigger & ~pin_s3_q.trigger;

    // ======================================================================
    // Register file.
    logic [15:0] smooth_q;
    logic [15:0] num_q [4];
    logic [15:0] den_q;
    logic [15:0] pgain_q;
    logic [15:0] ffg_q;
    logic [1:0]  ctrl_q;
    pcg_pos_t    tbl_q [8];
    pcg_bus_e    bus_q;
    logic [31:0] rd_val;
    logic [31:0] wr_val;
    logic [9:0]  idx;
    logic        wr_en;
    pcg_pos_t    cmd_q;
    pcg_pos_t    filt_q;
    pcg_pos_t    perr_q;

    assign idx   = avs_address[11:2];
    assign wr_en = (bus_q == PCG_BUS_ACK) && avs_write;

    // Out-of-range writes are pulled to the nearest legal value.
    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // Read multiplexer; unmapped words read as zero.
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (idx)
            `PCG_IDX_SMOOTH:  rd_val = {16'h0000, smooth_q};
            `PCG_IDX_NUM1:    rd_val = {16'h0000, num_q[0]};
            `PCG_IDX_NUM2:    rd_val = {16'h0000, num_q[1]};
            `PCG_IDX_NUM3:    rd_val = {16'h0000, num_q[2]};
            `PCG_IDX_NUM4:    rd_val = {16'h0000, num_q[3]};
            `PCG_IDX_DEN:     rd_val = {16'h0000, den_q};
            `PCG_IDX_PGAIN:   rd_val = {16'h0000, pgain_q};
            `PCG_IDX_FFG:     rd_val = {16'h0000, ffg_q};
            `PCG_IDX_CTRL:    rd_val = {30'h0000_0000, ctrl_q};
            `PCG_IDX_CMDPOS:  rd_val = cmd_q;
            `PCG_IDX_FILTPOS: rd_val = filt_q;
            `PCG_IDX_PERR:    rd_val = perr_q;
            default: begin
                if (idx[9:3] == `PCG_IDX_TBL_HI) begin
                    rd_val = tbl_q[idx[2:0]];
                end
            end
        endcase
    end

    // Byte lanes merge the write into the current word.
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign wr_val[gb*8 +: 8] = avs_byteenable[gb] ?
                avs_writedata[gb*8 +: 8] : rd_val[gb*8 +: 8];
        end
    endgenerate

    // Handshake: one wait cycle, then data stand while waitrequest is low.
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            bus_q           <= PCG_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            unique case (bus_q)
                PCG_BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_q           <= PCG_BUS_ACK;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= avs_read ? rd_val : 32'h0000_0000;
                    end
                end
                PCG_BUS_ACK: begin
                    bus_q           <= PCG_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Gear and gain settings, held to their legal spans.
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            smooth_q <= `PCG_RST_SMOOTH;
            num_q[0] <= `PCG_RST_GEAR;
            num_q[1] <= `PCG_RST_GEAR;
            num_q[2] <= `PCG_RST_GEAR;
            num_q[3] <= `PCG_RST_GEAR;
            den_q    <= `PCG_RST_GEAR;
            pgain_q  <= `PCG_RST_PGAIN;
            ffg_q    <= `PCG_RST_FFG;
            ctrl_q   <= 2'h0;
        end else if (wr_en) begin
            unique case (idx)
                `PCG_IDX_SMOOTH: smooth_q <= clamp(wr_val[15:0],
                    `PCG_SMOOTH_MIN, `PCG_SMOOTH_MAX);
                `PCG_IDX_NUM1: num_q[0] <= clamp(wr_val[15:0],
                    `PCG_GEAR_MIN, `PCG_GEAR_MAX);
                `PCG_IDX_NUM2: num_q[1] <= clamp(wr_val[15:0],
                    `PCG_GEAR_MIN, `PCG_GEAR_MAX);
                `PCG_IDX_NUM3: num_q[2] <= clamp(wr_val[15:0],
                    `PCG_GEAR_MIN, `PCG_GEAR_MAX);
                `PCG_IDX_NUM4: num_q[3] <= clamp(wr_val[15:0],
                    `PCG_GEAR_MIN, `PCG_GEAR_MAX);
                `PCG_IDX_DEN: den_q <= clamp(wr_val[15:0],
                    `PCG_GEAR_MIN, `PCG_GEAR_MAX);
                `PCG_IDX_PGAIN: pgain_q <= clamp(wr_val[15:0],
                    `PCG_PGAIN_MIN, `PCG_PGAIN_MAX);
                `PCG_IDX_FFG: ffg_q <= clamp(wr_val[15:0],
                    `PCG_FFG_MIN, `PCG_FFG_MAX);
                `PCG_IDX_CTRL: ctrl_q <= wr_val[1:0];
                default: begin
                end
            endcase
        end
    end

    // Internal position table of eight absolute targets.
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            for (int i = 0; i < 8; i++) begin
                tbl_q[i] <= '0;
            end
        end else if (wr_en && idx[9:3] == `PCG_IDX_TBL_HI) begin
            tbl_q[idx[2:0]] <= wr_val;
        end
    end

    // ======================================================================
    // Electronic gear.
    logic        pos_mode;
    logic        int_mode;
    logic        pulse_ok;
    logic [15:0] num_act;
    pcg_pos_t    rem_q;
    pcg_pos_t    num_s;
    pcg_pos_t    den_s;
    logic        step_up;
    logic        step_dn;

    assign pos_mode = ctrl_q[`PCG_CTRL_POS];
    assign int_mode = ctrl_q[`PCG_CTRL_INT];
    // Inhibit drops pulses at the source; steps already owed in the remainder still come out.
    assign pulse_ok = pulse_ev & pos_mode & ~int_mode
                    & ~pin_s2_q.inhibit;
    assign num_act  = num_q[pin_s2_q.num_sel];
    assign num_s    = {16'h0000, num_act};
    assign den_s    = {16'h0000, den_q};
    assign step_up  = rem_q >= den_s;
    assign step_dn  = rem_q <= -den_s;

    // Each pulse adds N signed by direction and each output step takes M back, so the
    // remainder carries the fraction exactly. Output runs one step a
    // cycle: input pulses must be spaced wider than the ratio.
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            rem_q <= '0;
        end else if (int_mode && trig_ev) begin
            rem_q <= '0;
        end else begin
            rem_q <= rem_q
                + (pulse_ok ? (pin_s2_q.dir ? -num_s : num_s) : '0)
                - (step_up ? den_s : '0)
                + (step_dn ? den_s : '0);
        end
    end

    // Command position: gear steps, or a table target on the trigger.
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            cmd_q <= '0;
        end else if (int_mode && trig_ev) begin
            cmd_q <= tbl_q[pin_s2_q.select];
        end else if (step_up) begin
            cmd_q <= cmd_q + 32'sd1;
        end else if (step_dn) begin
            cmd_q <= cmd_q - 32'sd1;
        end
    end

    // ======================================================================
    // Smoothing filter and loop gains.
    logic [31:0] tick_q;
    logic        tick;
    logic [15:0] tau_ms;
    logic [3:0]  shift;
    pcg_pos_t    ferr;
    pcg_pos_t    fstep;
    pcg_pos_t    fprev_q;
    logic signed [47:0] spd;

    assign tick   = tick_q == 32'(SAMPLE_CYCLES - 1);
    assign tau_ms = 16'(smooth_q * `PCG_SMOOTH_UNIT);
    assign ferr   = cmd_q - filt_q;

    // The gain is a power of two near 1/tau: cheaper than a divider at
    // the cost of a time constant accurate only to a factor of two.
    always_comb begin
        shift = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (tau_ms[i]) begin
                shift = 4'(i);
            end
        end
        fstep = ferr >>> shift;
        if (fstep == '0 && ferr != '0) begin
            fstep = ferr[31] ? -32'sd1 : 32'sd1;
        end
    end

    // Sample-period counter.
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            tick_q <= 32'h0000_0000;
        end else begin
            tick_q <= tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
        end
    end

    // Filtered position; a zero constant follows the command at once.
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            filt_q  <= '0;
            fprev_q <= '0;
        end else if (smooth_q == `PCG_SMOOTH_MIN) begin
            filt_q <= cmd_q;
            if (tick) begin
                fprev_q <= filt_q;
            end
        end else if (tick) begin
            filt_q  <= filt_q + fstep;
            fprev_q <= filt_q;
        end
    end

    assign spd = 48'(perr_q) * $signed({32'h0000_0000, pgain_q})
               + 48'(filt_q - fprev_q) * $signed({32'h0000_0000, ffg_q})
                 / `PCG_FFG_SCALE;

    // Loop outputs update once per sample; outside position mode the
    // speed reference is held at zero.
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            perr_q          <= '0;
            speed_reference <= '0;
        end else if (tick) begin
            perr_q          <= filt_q - feedback_position;
            speed_reference <= pos_mode ? spd[31:0] : '0;
        end
    end

    // Registered copies for the outputs.
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            command_position  <= '0;
            smoothed_position <= '0;
            position_error    <= '0;
        end else begin
            command_position  <= cmd_q;
            smoothed_position <= filt_q;
            position_error    <= perr_q;
        end
    end
endmodule
`default_nettype wire

// >>> sim/pcg_checker.sv
// Port-level assertions for the gearing block.
`default_nettype none
`include "pcg_consts.svh"
module pcg_checker
    import pcg_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [11:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire pcg_pins_s   pins,
    input wire pcg_pos_t    command_position,
    input wire pcg_pos_t    smoothed_position
);
    // ======================================================================
    // Mirrors of the mode and smoothing settings.
    logic       int_q;
    logic       smz_q;
    logic       wr_w;
    logic       rd_w;
    logic [9:0] idx_w;

    // Only completed writes count, as in the slave itself.
    assign wr_w  = avs_write && !avs_waitrequest;
    assign rd_w  = avs_read && !avs_waitrequest;
    assign idx_w = avs_address[11:2];

    // Full lane writes are assumed; the bench never uses partial ones.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            int_q <= 1'b0;
            smz_q <= 1'b1;
        end else if (wr_w && idx_w == `PCG_IDX_CTRL) begin
            int_q <= avs_writedata[`PCG_CTRL_INT];
        end else if (wr_w && idx_w == `PCG_IDX_SMOOTH) begin
            smz_q <= (avs_writedata[15:0] == 16'h0000);
        end
    end

    // ======================================================================
    // Assertions.
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_wait_single: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    a_wait_release: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle: assert property (
        !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without a request");
    a_gear_range: assert property (
        rd_w && idx_w inside {`PCG_IDX_NUM1, `PCG_IDX_DEN}
        |-> avs_readdata inside {[`PCG_GEAR_MIN:`PCG_GEAR_MAX]})
        else $error("gear out of range");
    a_smooth_range: assert property (
        rd_w && idx_w == `PCG_IDX_SMOOTH |-> avs_readdata <= `PCG_SMOOTH_MAX)
        else $error("smoothing out of range");
    a_pgain_range: assert property (
        rd_w && idx_w == `PCG_IDX_PGAIN |-> avs_readdata <= `PCG_PGAIN_MAX)
        else $error("loop gain out of range");
    a_ffg_range: assert property (
        rd_w && idx_w == `PCG_IDX_FFG
        |-> avs_readdata inside {[`PCG_FFG_MIN:`PCG_FFG_MAX]})
        else $error("feed-forward gain out of range");
    a_cmd_step: assert property (
        !int_q && !$past(int_q)
        |-> (command_position - $past(command_position))
            inside {-32'sd1, 32'sd0, 32'sd1})
        else $error("command moved more than one step");
    a_inhibit_hold: assert property (
        (pins.inhibit && !int_q)[*8] |-> $stable(command_position))
        else $error("command moved while inhibited");
    a_filter_bypass: assert property (
        (smz_q && $stable(command_position))[*4]
        |-> smoothed_position == command_position)
        else $error("bypass failed");

    c_read_done: cover property (rd_w && idx_w == 10'h12C);
    c_trigger: cover property ($rose(pins.trigger) && int_q);
    c_inhibit: cover property (pins.inhibit[*8]);
endmodule

bind pcg_top pcg_checker pcg_checker_i (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pins(pins),
    .command_position(command_position),
    .smoothed_position(smoothed_position)
);
`default_nettype wire

// >>> sim/pcg_ctrl_model.sv
// Behavioural motion controller that drives the command pins.
`default_nettype none
module pcg_ctrl_model
    import pcg_pkg::*;
(
    input  wire logic      mclk,
    output var pcg_pins_s  pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================================================
    // All lines start low; pulse stays low between bursts.
    initial begin
        pins = '0;
    end

    // Levels last four cycles so the three-flop synchroniser sees them.
    task automatic send_pulses(input int n, input logic neg, input int gap);
        @(posedge mclk);
        pins.dir <= neg;
        repeat (4) @(posedge mclk);
        repeat (n) begin
            pins.pulse <= 1'b1;
            repeat (4) @(posedge mclk);
            pins.pulse <= 1'b0;
            repeat (gap) @(posedge mclk);
        end
    endtask

    // Inhibit and numerator choice change only while pulses are idle.
    task automatic set_lines(input logic inh, input logic [1:0] sel);
        @(posedge mclk);
        pins.inhibit <= inh;
        pins.num_sel <= sel;
    endtask

    // The selection settles before the trigger contact closes.
    task automatic move(input logic [2:0] sel);
        @(posedge mclk);
        pins.select <= sel;
        repeat (4) @(posedge mclk);
        pins.trigger <= 1'b1;
        repeat (4) @(posedge mclk);
        pins.trigger <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// >>> sim/pcg_top_tb_top.sv
// Self-checking bench of the gearing block.
`default_nettype none
module pcg_top_tb_top
    import pcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk;
    logic        rst_n;
    logic [11:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    pcg_pins_s   pins;
    pcg_pos_t    fb_pos;
    pcg_pos_t    cmd_pos;
    pcg_pos_t    smooth_pos;
    pcg_pos_t    pos_err;
    pcg_pos_t    speed_ref;
    int          error_cnt;
    int          check_count;

    // ======================================================================
    // Clock, design and controller.
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    pcg_top #(.SAMPLE_CYCLES(4)) pcg_top_i (
        .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pins(pins), .feedback_position(fb_pos),
        .command_position(cmd_pos), .smoothed_position(smooth_pos),
        .position_error(pos_err), .speed_reference(speed_ref)
    );
    pcg_ctrl_model pcg_ctrl_model_i (.mclk(mclk), .pins(pins));

    // ======================================================================
    // Shared tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Called just after a rising edge; the request stands until the edge
    // at which waitrequest is seen low, where read data are taken too.
    task automatic bus(input logic wr, input logic [9:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        avs_address   <= {idx, 2'b00};
        avs_writedata <= wd;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        if (avs_waitrequest !== 1'b0) error_cnt++;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, idx, 32'h0, x);
        chk(x, exp);
    endtask

    // Waits for the target, then again so late extra steps are caught.
    task automatic wait_cmd(input pcg_pos_t exp);
        int n;
        n = 0;
        while (cmd_pos !== exp && n < 300) begin
            @(negedge mclk);
            n++;
        end
        repeat (20) @(negedge mclk);
        chk(cmd_pos, exp);
        @(posedge mclk);
    endtask

    // ======================================================================
    // Scenarios.
    task automatic t_regs();
        logic [9:0]  ix [5] = '{10'h12C, 10'h12D, 10'h108, 10'h200, 10'h202};
        logic [31:0] rv [5] = '{32'h1, 32'h1, 32'h0, 32'h23, 32'h1388};
        logic [31:0] hi [5] = '{32'h7FFF, 32'h7FFF, 32'h3E8, 32'h3FF,
                                32'h4E20};
        logic [31:0] lo [5] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'hA};
        for (int i = 0; i < 5; i++) begin
            rd_chk(ix[i], rv[i]);
            wr(ix[i], 32'hFFFF);
            rd_chk(ix[i], hi[i]);
            wr(ix[i], 32'h0);
            rd_chk(ix[i], lo[i]);
            wr(ix[i], rv[i]);
        end
        wr(10'h3FF, 32'h55);
        rd_chk(10'h3FF, 32'h0);
    endtask

    // Ratios 3/2 and 5/2 are set while the drive is off.
    task automatic t_gear();
        wr(10'h12C, 32'h3);
        wr(10'h12D, 32'h2);
        wr(10'h300, 32'h5);
        wr(10'h310, 32'h1);
        pcg_ctrl_model_i.send_pulses(5, 1'b0, 8);
        wait_cmd(32'sd7);
        pcg_ctrl_model_i.set_lines(1'b0, 2'd1);
        pcg_ctrl_model_i.send_pulses(1, 1'b0, 8);
        wait_cmd(32'sd10);
        pcg_ctrl_model_i.send_pulses(2, 1'b1, 8);
        wait_cmd(32'sd5);
        rd_chk(10'h311, 32'h5);
    endtask

    task automatic t_inhibit();
        pcg_ctrl_model_i.set_lines(1'b1, 2'd1);
        pcg_ctrl_model_i.send_pulses(3, 1'b0, 8);
        wait_cmd(32'sd5);
        pcg_ctrl_model_i.set_lines(1'b0, 2'd0);
    endtask

    // Error is 5 - 3; at rest only the proportional term remains.
    task automatic t_loop();
        fb_pos <= 32'sd3;
        repeat (30) @(negedge mclk);
        chk(smooth_pos, 32'h5);
        chk(pos_err, 32'h2);
        chk(speed_ref, 32'd70);
        @(posedge mclk);
        wr(10'h310, 32'h0);
        repeat (30) @(negedge mclk);
        chk(speed_ref, 32'h0);
        @(posedge mclk);
    endtask

    task automatic t_trigger();
        wr(10'h323, 32'h1234);
        wr(10'h310, 32'h3);
        pcg_ctrl_model_i.move(3'd3);
        wait_cmd(32'sh1234);
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ======================================================================
    // Main sequence and watchdog.
    initial begin
        rst_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        fb_pos = '0;
        error_cnt = 0;
        check_count = 0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_regs();
        t_gear();
        t_inhibit();
        t_loop();
        t_trigger();
        report_and_stop();
    end

    // The whole run takes well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
